// >>> rtl/bcb_pkg.sv
// Shared constants, types and helpers for the bit-clear / branch executor.
// Assumes a single 250 MHz clock and word-aligned AHB-Lite register access.
package bcb_pkg;

	// ==========================================================
	// Widths and timing
	localparam int CLK_MHZ = 250;
	localparam int BANK_W = 4;
	localparam int ADDR_W = BANK_W + 8;
	localparam int MEM_N = 1 << ADDR_W;
	localparam int PC_W = 16;
	localparam int DIV_W = 8;
	localparam int QDIV_DFLT = 1;
	localparam int PH_PER_CYC = 4;
	localparam logic [PC_W-1:0] PC_STEP = 16'h0002;

	// ==========================================================
	// Instruction fields and encodings
	localparam logic [3:0] OPC_BCLR = 4'h9;
	localparam logic [3:0] BR_PFX = 4'hE;
	localparam logic [3:0] COND_NEG = 4'h6;
	localparam logic [3:0] COND_NOC = 4'h3;
	localparam logic [3:0] COND_POS = 4'h7;
	localparam int BIT_LSB = 9;
	localparam int ACC_BIT = 8;
	localparam logic [7:0] ACC_SPLIT = 8'h80;
	localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;

	// ==========================================================
	// Register map and fields
	localparam logic [31:0] REG_INSTR = 32'h0000_0000;
	localparam logic [31:0] REG_PC = 32'h0000_0004;
	localparam logic [31:0] REG_FLAGS = 32'h0000_0008;
	localparam logic [31:0] REG_BANK = 32'h0000_000C;
	localparam logic [31:0] REG_STAT = 32'h0000_0010;
	localparam logic [31:0] REG_MADDR = 32'h0000_0014;
	localparam logic [31:0] REG_MDATA = 32'h0000_0018;
	localparam int FLG_N = 0;
	localparam int FLG_C = 1;
	localparam int STAT_DONE = 1;
	localparam logic [PC_W-1:0] PC_RST = 16'h0000;
	localparam logic [1:0] FLAGS_RST = 2'h0;
	localparam logic [BANK_W-1:0] BANK_RST = 4'h0;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_Q1 = 3'b001,
		ST_Q2 = 3'b010,
		ST_Q3 = 3'b011,
		ST_Q4 = 3'b100,
		ST_NOP = 3'b101
	} bcb_state_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_BCLR = 3'b001,
		OP_BNEG = 3'b010,
		OP_BNOC = 3'b011,
		OP_BPOS = 3'b100
	} bcb_op_t;

	// ==========================================================
	// Helpers
	function automatic bcb_op_t fn_decode(input logic [15:0] i);
		bcb_op_t op;
		op = OP_NONE;
		if (i[15:12] == OPC_BCLR) begin
			op = OP_BCLR;
		end else if (i[15:12] == BR_PFX) begin
			case (i[11:8])
				COND_NEG: op = OP_BNEG;
				COND_NOC: op = OP_BNOC;
				COND_POS: op = OP_BPOS;
				default: op = OP_NONE;
			endcase
		end
		return op;
	endfunction

	function automatic logic [ADDR_W-1:0] fn_bank_addr(input logic a, input logic [7:0] f,
			input logic [BANK_W-1:0] bank);
		if (a) begin
			return {bank, f};
		end
		return (f < ACC_SPLIT) ? {ACC_LO_BANK, f} : {ACC_HI_BANK, f};
	endfunction

	function automatic logic [7:0] fn_clear(input logic [7:0] v, input logic [2:0] b);
		return v & ~(8'h01 << b);
	endfunction

	function automatic logic [PC_W-1:0] fn_target(input logic [PC_W-1:0] pc, input logic [7:0] n);
		return pc + {{(PC_W-9){n[7]}}, n, 1'b0};
	endfunction

endpackage

// >>> rtl/bcb_exec_if.sv
// Link between the register/memory shell and the phase sequencer.
// Assumes both ends share hclk.
`timescale 1ns/100ps
`default_nettype none
interface bcb_exec_if;
	import bcb_pkg::*;
	logic start;
	logic [15:0] instr;
	logic flag_n;
	logic flag_c;
	logic [BANK_W-1:0] bank;
	logic [PC_W-1:0] pc;
	logic [7:0] mem_rdata;
	logic [ADDR_W-1:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic pc_we;
	logic [PC_W-1:0] pc_new;
	logic tgt_we;
	logic tick;
	logic busy;
	logic done;
	logic taken;
	bcb_op_t op;
	bcb_state_t state;
	logic [15:0] cur_instr;
	modport core (input start, instr, flag_n, flag_c, bank, pc, mem_rdata,
		output mem_addr, mem_we, mem_wdata, pc_we, pc_new, tgt_we, tick, busy, done, taken,
		op, state, cur_instr);
	modport shell (output start, instr, flag_n, flag_c, bank, pc, mem_rdata,
		input mem_addr, mem_we, mem_wdata, pc_we, pc_new, tgt_we, tick, busy, done, taken,
		op, state, cur_instr);
endinterface
`default_nettype wire

// >>> rtl/bcb_exec_seq.sv
// Four-phase sequencer that decodes and executes one instruction.
// Assumes the shell returns memory read data one clock after the address.
`timescale 1ns/100ps
`default_nettype none
module bcb_exec_seq import bcb_pkg::*; #(
	parameter int Q_DIV = QDIV_DFLT
) (
	input wire logic hclk,
	input wire logic hresetn,
	bcb_exec_if.core ex
);
	// ==========================================================
	// Phase divider
	logic [DIV_W-1:0] div_q;
	bcb_state_t state_q;
	bcb_op_t op_q;
	logic [15:0] instr_q;
	logic [7:0] mod_q;
	logic [1:0] nop_q;
	logic taken_q;
	logic cond;
	logic tick;

	assign tick = (div_q == DIV_W'(Q_DIV - 1));

	// Free-running phase enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= '0;
		end else begin
			div_q <= tick ? '0 : div_q + 1'b1;
		end
	end

	// ==========================================================
	// Condition and outputs
	assign cond = (op_q == OP_BNEG && ex.flag_n) ||
		(op_q == OP_BNOC && !ex.flag_c) ||
		(op_q == OP_BPOS && !ex.flag_n);
	assign ex.mem_addr = fn_bank_addr(instr_q[ACC_BIT], instr_q[7:0], ex.bank);
	assign ex.mem_wdata = mod_q;
	assign ex.mem_we = tick && state_q == ST_Q4 && op_q == OP_BCLR;
	assign ex.tgt_we = tick && state_q == ST_Q4 && cond;
	assign ex.pc_we = (tick && state_q == ST_Q1) || ex.tgt_we;
	assign ex.pc_new = ex.tgt_we ? fn_target(ex.pc, instr_q[7:0]) : ex.pc + PC_STEP;
	assign ex.tick = tick;
	assign ex.busy = (state_q != ST_IDLE);
	assign ex.done = tick && ((state_q == ST_Q4 && !cond) || (state_q == ST_NOP && nop_q == 2'h3));
	assign ex.taken = taken_q;
	assign ex.op = op_q;
	assign ex.state = state_q;
	assign ex.cur_instr = instr_q;

	// ==========================================================
	// Phase state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			op_q <= OP_NONE;
			instr_q <= 16'h0000;
			mod_q <= 8'h00;
			nop_q <= 2'h0;
			taken_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: if (ex.start) begin
					instr_q <= ex.instr;
					op_q <= fn_decode(ex.instr);
					taken_q <= 1'b0;
					nop_q <= 2'h0;
					state_q <= ST_Q1;
				end
				ST_Q1: if (tick) state_q <= ST_Q2;
				ST_Q2: if (tick) state_q <= ST_Q3;
				ST_Q3: if (tick) begin
					mod_q <= fn_clear(ex.mem_rdata, instr_q[BIT_LSB+:3]);
					state_q <= ST_Q4;
				end
				ST_Q4: if (tick) begin
					taken_q <= cond;
					state_q <= cond ? ST_NOP : ST_IDLE;
				end
				ST_NOP: if (tick) begin
					nop_q <= nop_q + 1'b1;
					if (nop_q == 2'h3) state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> rtl/bcb_top.sv
// Top of the bit-clear / conditional-branch executor with AHB-Lite registers.
// Assumes a single-master AHB-Lite bus on hclk; hready is the bus ready.
// What this block does
// - Bit clear zeroes one indexed bit only
// - Override bit zero selects fast-access bank
// - Override bit one uses bank select register
// - Negative branch taken when negative flag set
// - No-carry branch taken when carry clear
// - Positive branch taken when negative clear
// - Offset is signed, doubled, added to counter
// - Target is branch address plus two plus offset
// - Branch takes one cycle, two when taken
// - Decode branch prefix and condition nibbles
`timescale 1ns/100ps
`default_nettype none
module bcb_top import bcb_pkg::*; #(
	parameter int Q_DIV = QDIV_DFLT
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	// ==========================================================
	// Declarations
	bcb_exec_if ex ();

	logic [7:0] mem [0:MEM_N-1];
	logic [PC_W-1:0] pc_q;
	logic [1:0] flags_q;
	logic [BANK_W-1:0] bank_q;
	logic [ADDR_W-1:0] maddr_q;
	logic [7:0] mem_rd_q;
	logic done_q;
	logic [3:0] ph_run_q;
	logic [3:0] ph_cnt_q;
	logic wr_pend_q;
	logic [31:0] wr_addr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;

	logic acc;
	logic rd_acc;
	logic wr_instr;
	logic wr_pc;
	logic wr_flags;
	logic wr_bank;
	logic wr_stat;
	logic wr_maddr;
	logic wr_mdata;
	logic sw_ok;
	logic [31:0] stat_word;
	logic [31:0] rd_word;

	// ==========================================================
	// Sequencer
	bcb_exec_seq #(
		.Q_DIV(Q_DIV)
	) u_seq (
		.hclk(hclk),
		.hresetn(hresetn),
		.ex(ex)
	);

	assign ex.start = wr_instr && !ex.busy;
	assign ex.instr = hwdata[15:0];
	assign ex.flag_n = flags_q[FLG_N];
	assign ex.flag_c = flags_q[FLG_C];
	assign ex.bank = bank_q;
	assign ex.pc = pc_q;
	assign ex.mem_rdata = mem_rd_q;

	// ==========================================================
	// Bus decode
	// Address phase accepted on a NONSEQ or SEQ with hready high
	assign acc = hsel && hready && htrans[1];
	assign rd_acc = acc && !hwrite;
	// Software may only touch state, apart from the done clear in status, while no instruction runs
	assign sw_ok = !ex.busy;
	assign wr_instr = wr_pend_q && wr_addr_q == REG_INSTR;
	assign wr_pc = wr_pend_q && wr_addr_q == REG_PC && sw_ok;
	assign wr_flags = wr_pend_q && wr_addr_q == REG_FLAGS && sw_ok;
	assign wr_bank = wr_pend_q && wr_addr_q == REG_BANK && sw_ok;
	assign wr_stat = wr_pend_q && wr_addr_q == REG_STAT;
	assign wr_maddr = wr_pend_q && wr_addr_q == REG_MADDR && sw_ok;
	assign wr_mdata = wr_pend_q && wr_addr_q == REG_MDATA && sw_ok;

	// Status: phase count, last taken, done, busy
	assign stat_word = {24'h000000, ph_cnt_q, 1'b0, ex.taken, done_q, ex.busy};

	// Read mux; unmapped reads return zero
	assign rd_word = (haddr == REG_INSTR) ? {16'h0000, ex.cur_instr} :
		(haddr == REG_PC) ? {16'h0000, pc_q} :
		(haddr == REG_FLAGS) ? {30'h00000000, flags_q} :
		(haddr == REG_BANK) ? {28'h0000000, bank_q} :
		(haddr == REG_STAT) ? stat_word :
		(haddr == REG_MADDR) ? {20'h00000, maddr_q} :
		(haddr == REG_MDATA) ? {24'h000000, mem[maddr_q]} : 32'h0000_0000;

	// ==========================================================
	// Bus phase tracking and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
			wr_pend_q <= acc && hwrite;
			if (acc) wr_addr_q <= haddr;
			if (rd_acc) hrdata_q <= rd_word;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = 1'b0;

	// ==========================================================
	// Architectural registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_q <= PC_RST;
			flags_q <= FLAGS_RST;
			bank_q <= BANK_RST;
			maddr_q <= '0;
		end else begin
			if (ex.pc_we) begin
				pc_q <= ex.pc_new;
			end else if (wr_pc) begin
				pc_q <= hwdata[PC_W-1:0];
			end
			// Flags change only by software, never by execution
			if (wr_flags) flags_q <= hwdata[1:0];
			if (wr_bank) bank_q <= hwdata[BANK_W-1:0];
			if (wr_maddr) maddr_q <= hwdata[ADDR_W-1:0];
		end
	end

	// Done is sticky; a new completion beats a software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= ex.done || (done_q && !(wr_stat && hwdata[STAT_DONE]));
		end
	end

	// Phases spent by the running instruction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_run_q <= 4'h0;
			ph_cnt_q <= 4'h0;
		end else begin
			if (ex.start) begin
				ph_run_q <= 4'h0;
			end else if (ex.busy && ex.tick) begin
				ph_run_q <= ph_run_q + 1'b1;
			end
			if (ex.done) ph_cnt_q <= ph_run_q + 1'b1;
		end
	end

	// ==========================================================
	// Data memory
	// Execution write has priority; software writes are held off while busy
	always_ff @(posedge hclk) begin
		if (ex.mem_we) begin
			mem[ex.mem_addr] <= ex.mem_wdata;
		end else if (wr_mdata) begin
			mem[maddr_q] <= hwdata[7:0];
		end
	end

	// Registered read port for the execution path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_rd_q <= 8'h00;
		end else begin
			mem_rd_q <= mem[ex.mem_addr];
		end
	end

	// ==========================================================
	// Checks
	logic [PC_W-1:0] pc_start_q;
	logic [15:0] ins;

	assign ins = ex.cur_instr;

	// Address of the running instruction, for target checks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_start_q <= PC_RST;
		end else if (ex.start) begin
			pc_start_q <= pc_q;
		end
	end

	property p_clear_bit;
		@(posedge hclk) disable iff (!hresetn)
		ex.mem_we |-> ex.mem_wdata[ins[BIT_LSB+:3]] == 1'b0 &&
			(ex.mem_wdata | (8'h01 << ins[BIT_LSB+:3])) ==
			(mem_rd_q | (8'h01 << ins[BIT_LSB+:3]));
	endproperty
	a_clear_bit: assert property (p_clear_bit) else $error("bit clear value wrong");

	property p_access_bank;
		@(posedge hclk) disable iff (!hresetn)
		ex.mem_we && !ins[ACC_BIT] |->
			ex.mem_addr[ADDR_W-1:8] == (ins[7] ? ACC_HI_BANK : ACC_LO_BANK);
	endproperty
	a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

	property p_bsr_bank;
		@(posedge hclk) disable iff (!hresetn)
		ex.mem_we && ins[ACC_BIT] |-> ex.mem_addr == {bank_q, ins[7:0]};
	endproperty
	a_bsr_bank: assert property (p_bsr_bank) else $error("selected bank wrong");

	property p_neg_branch;
		@(posedge hclk) disable iff (!hresetn)
		ex.tick && ex.state == ST_Q4 && ex.op == OP_BNEG |-> ex.tgt_we == ex.flag_n;
	endproperty
	a_neg_branch: assert property (p_neg_branch) else $error("negative branch wrong");

	property p_nocarry_branch;
		@(posedge hclk) disable iff (!hresetn)
		ex.tick && ex.state == ST_Q4 && ex.op == OP_BNOC |-> ex.tgt_we == !ex.flag_c;
	endproperty
	a_nocarry_branch: assert property (p_nocarry_branch) else $error("no-carry branch wrong");

	property p_pos_branch;
		@(posedge hclk) disable iff (!hresetn)
		ex.tick && ex.state == ST_Q4 && ex.op == OP_BPOS |-> ex.tgt_we == !ex.flag_n;
	endproperty
	a_pos_branch: assert property (p_pos_branch) else $error("positive branch wrong");

	property p_offset;
		@(posedge hclk) disable iff (!hresetn)
		ex.tgt_we |-> ex.pc_new ==
			pc_start_q + PC_STEP + {{(PC_W-9){ins[7]}}, ins[7:0], 1'b0};
	endproperty
	a_offset: assert property (p_offset) else $error("branch offset wrong");

	property p_target;
		@(posedge hclk) disable iff (!hresetn)
		ex.tgt_we |=> pc_q == fn_target(pc_start_q + PC_STEP, ins[7:0]);
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong");

	property p_cycles;
		@(posedge hclk) disable iff (!hresetn)
		ex.done |=> ph_cnt_q == (ex.taken ? 4'(2 * PH_PER_CYC) : 4'(PH_PER_CYC));
	endproperty
	a_cycles: assert property (p_cycles) else $error("instruction length wrong");

	property p_decode;
		@(posedge hclk) disable iff (!hresetn)
		ex.busy && (ex.op == OP_BNEG || ex.op == OP_BNOC || ex.op == OP_BPOS) |->
			ins[15:12] == BR_PFX;
	endproperty
	a_decode: assert property (p_decode) else $error("branch decode wrong");

	property p_nop_cycle;
		@(posedge hclk) disable iff (!hresetn)
		ex.tgt_we |=> (ex.busy && !ex.pc_we && !ex.mem_we)[*4];
	endproperty
	a_nop_cycle: assert property (p_nop_cycle) else $error("taken branch not idle");

	property p_flags_kept;
		@(posedge hclk) disable iff (!hresetn)
		ex.busy && $past(ex.busy) |-> $stable(flags_q);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

	property p_write_phase;
		@(posedge hclk) disable iff (!hresetn)
		ex.mem_we |-> ex.op == OP_BCLR && ph_run_q == 4'(PH_PER_CYC - 1);
	endproperty
	a_write_phase: assert property (p_write_phase) else $error("write outside last phase");

endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the bit-clear / conditional-branch executor.
// Assumes one AHB-Lite master (this bench) and the top's ready looped back as hready.
`timescale 1ns/100ps
`default_nettype none
module tb_top import bcb_pkg::*;;
	// ==========================================================
	// Bench signals
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp;
	wire logic hready;
	int errors, comparisons, cycles;
	localparam int LIMIT = 20000;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	// Slower phase rate than default; phase counts stay the same
	bcb_top #(.Q_DIV(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

	// ==========================================================
	// Clock and hang guard
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors = errors + 1;
			print_verdict();
		end
	end

	// ==========================================================
	// Compare, verdict and bus tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One single word transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		xfer(1'b1, a, d, rd);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		xfer(1'b0, a, 32'h0000_0000, rd);
		check(rd, exp);
	endtask

	// Start one instruction and poll busy with a bounded count
	task automatic run_instr(input logic [15:0] ins);
		logic [31:0] rd;
		int k;
		wr(REG_INSTR, {16'h0000, ins});
		k = 0;
		do begin
			xfer(1'b0, REG_STAT, 32'h0000_0000, rd);
			k = k + 1;
		end while (rd[0] !== 1'b0 && k < 60);
		check({31'h0, rd[0]}, 32'h0000_0000);
	endtask

	task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
		wr(REG_MADDR, {20'h00000, a});
		wr(REG_MDATA, {24'h000000, v});
	endtask

	task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
		wr(REG_MADDR, {20'h00000, a});
		rd_chk(REG_MDATA, {24'h000000, v});
	endtask

	// ==========================================================
	// Main sequence
	logic [3:0] conds [3] = '{4'h6, 4'h3, 4'h7};
	logic [15:0] pcs [4] = '{16'h1000, 16'h0000, 16'hFFF0, 16'h2468};
	logic [7:0] offs [4] = '{8'h7F, 8'h80, 8'h01, 8'hFF};
	logic [11:0] acc_a [2] = '{12'h020, 12'hFA0};
	logic [11:0] bsr_a [2] = '{12'h320, 12'h3A0};
	logic [2:0] acc_b [2] = '{3'h0, 3'h7};

	initial begin
		logic [7:0] f;
		logic tk;
		logic [15:0] tgt;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// Reset values and an unmapped word
		rd_chk(REG_PC, 32'h0000_0000);
		rd_chk(REG_FLAGS, 32'h0000_0000);
		rd_chk(REG_BANK, 32'h0000_0000);
		rd_chk(REG_STAT, 32'h0000_0000);
		rd_chk(REG_MADDR, 32'h0000_0000);
		wr(32'h0000_0040, 32'hFFFF_FFFF);
		rd_chk(32'h0000_0040, 32'h0000_0000);
		// Bit clear through the bank select register, every bit index
		wr(REG_BANK, 32'h0000_0003);
		wr(REG_FLAGS, 32'h0000_0003);
		for (int b = 0; b < 8; b++) begin
			f = 8'h10 + 8'(b) * 8'h11;
			mem_wr({4'h3, f}, 8'hFF);
			mem_wr({4'h0, f}, 8'hFF);
			wr(REG_PC, 32'h0000_0100);
			run_instr({4'h9, 3'(b), 1'b1, f});
			mem_chk({4'h3, f}, 8'hFF & ~(8'h01 << b));
			mem_chk({4'h0, f}, 8'hFF);
			rd_chk(REG_FLAGS, 32'h0000_0003);
			rd_chk(REG_STAT, 32'h0000_0042);
			rd_chk(REG_PC, 32'h0000_0102);
		end
		// Fast-access bank ignores the bank select register
		for (int i = 0; i < 2; i++) begin
			mem_wr(acc_a[i], 8'hFF);
			mem_wr(bsr_a[i], 8'hFF);
			run_instr({4'h9, acc_b[i], 1'b0, acc_a[i][7:0]});
			mem_chk(acc_a[i], 8'hFF & ~(8'h01 << acc_b[i]));
			mem_chk(bsr_a[i], 8'hFF);
		end
		// Each branch kind against every flag combination
		for (int c = 0; c < 3; c++) begin
			for (int fl = 0; fl < 4; fl++) begin
				case (c)
					0: tk = fl[0];
					1: tk = ~fl[1];
					default: tk = ~fl[0];
				endcase
				tgt = pcs[fl] + 16'h0002;
				if (tk) begin
					tgt = tgt + {{7{offs[fl][7]}}, offs[fl], 1'b0};
				end
				wr(REG_PC, {16'h0000, pcs[fl]});
				wr(REG_FLAGS, 32'(fl));
				run_instr({4'hE, conds[c], offs[fl]});
				rd_chk(REG_PC, {16'h0000, tgt});
				rd_chk(REG_STAT, tk ? 32'h0000_0086 : 32'h0000_0042);
				rd_chk(REG_FLAGS, 32'(fl));
			end
		end
		// Branch prefix with an unused condition runs as a plain no-op
		// Writes while it runs, a second start included, are dropped
		wr(REG_PC, 32'h0000_3000);
		wr(REG_FLAGS, 32'h0000_0000);
		wr(REG_INSTR, 32'h0000_E540);
		wr(REG_FLAGS, 32'h0000_0003);
		run_instr(16'hE540);
		rd_chk(REG_PC, 32'h0000_3002);
		rd_chk(REG_STAT, 32'h0000_0042);
		rd_chk(REG_FLAGS, 32'h0000_0000);
		print_verdict();
	end
endmodule
`default_nettype wire
